// File: scd_regs.svh
// Register offsets, field positions, reset values and timing figures.
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
`define SCD_ADDR_CRD 16'hfe05
`define SCD_ADDR_STX 16'hfe06
`define SCD_CRD_RESET 8'h00
`define SCD_STX_RESET 8'h00
`define SCD_RD_NONE 8'h00
`define SCD_CRD_DEB 7
`define SCD_CRD_EN 6
`define SCD_CRD_POL 3
`define SCD_CRD_PU 2
`define SCD_CRD_PD 1
`define SCD_CRD_PRES 0
`define SCD_STX_DIO 7
`define SCD_STX_FULL 5
`define SCD_STX_EMPTY 4
`define SCD_STX_UNDR 3
`define SCD_STX_LAST 2
`define SCD_STX_DIR 1
`define SCD_STX_BRK 0
`define SCD_CLK_NS 40
`define SCD_TICK_NS 1000000
`define SCD_TICK_CYCLES (`SCD_TICK_NS / `SCD_CLK_NS)
`define SCD_DEBOUNCE_MS 7'd64
`define SCD_LEN_MAX 8'hff
`define SCD_LEN_ZERO 8'h00
`endif

// File: scd_pkg.sv
// Types shared by the card detect and transmit control block.
package scd_pkg;
  typedef enum logic [1:0] {
    DIR_RX,
    DIR_TX,
    DIR_DRAIN
  } scd_dir_type;

  typedef struct packed {
    logic sync_mode;
    logic t1_mode;
    logic check_code_en;
  } scd_mode_type;

  typedef struct packed {
    logic fifo_full;
    logic fifo_empty;
    logic word_sent;
    logic crc_sent;
    logic break_window;
  } scd_tx_stat_type;
endpackage

// File: scd_ctrl.sv
// Card presence detection and transmit control with its register port.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "scd_regs.svh"

// Function
// - Presence detection keeps working while the card logic clock stops.
// - With power-down set, presence is reported without any debounce.
// - Debounce counts 1 kHz ticks; presence only after 64 ms asserted.
// - Presence clears at once when the detect input deasserts.
// - Detect enable activates the input and resets to zero.
// - Polarity one means high is present; zero means low is present.
// - Bit 2 low enables pull-up; bit 1 high enables pull-down.
// - Presence bit reads one when inserted; every change is a card event.
// - Sync direct-IO with length max or zero drives IO from control bit.
// - Full flag stands while full and raises a transmit event.
// - Empty flag follows the FIFO; send in transmit mode; event on empty.
// - In T=1 with last and check code, empty waits for the check code.
// - In T=0 with last, empty waits for the final word sent.
// - Underrun flag on empty after a word without last; clear on read.
// - After last byte is flagged, T=1 appends the check code.
// - Direction one is transmit, zero receive; picks the counters.
// - Setting then resetting direction reinitialises the check code logic.
// - With last set, receive request waits until transmit is empty.
// - Break on IO sets a flag, cleared on read, with an error event.
// - A card event starts deactivation, as supply-stable falling does.
module scd_ctrl
  import scd_pkg::*;
#(
  parameter int TICK_CYCLES = `SCD_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic card_detect_pin_i,
  input wire logic power_down_bit_i,
  input wire logic supply_stable_i,
  output logic pullup_enable_n_o,
  output logic pulldown_enable_o,
  output logic card_present_o,
  output logic card_event_o,
  output logic deactivate_o,
  input wire scd_mode_type mode_i,
  input wire logic [7:0] length_count_i,
  input wire logic card_io_bit_i,
  input wire logic fifo_bit_i,
  input wire scd_tx_stat_type tx_stat_i,
  input wire logic io_line_i,
  input wire logic card_clk_i,
  output logic io_out_o,
  output logic tx_mode_o,
  output logic rx_mode_o,
  output logic send_enable_o,
  output logic append_check_o,
  output logic crc_init_o,
  output logic tx_event_irq_o,
  output logic tx_error_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Register port decode
  wire sel_crd = reg_addr_i == `SCD_ADDR_CRD;
  wire sel_stx = reg_addr_i == `SCD_ADDR_STX;
  wire wr_crd = reg_wr_i & sel_crd;
  wire wr_stx = reg_wr_i & sel_stx;
  wire rd_stx = reg_rd_i & sel_stx;
  logic [7:0] crd_q;
  logic direct_io_q;
  logic last_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      crd_q <= `SCD_CRD_RESET;
      direct_io_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      if (wr_crd) begin
        crd_q <= reg_wdata_i;
      end
      if (wr_stx) begin
        direct_io_q <= reg_wdata_i[`SCD_STX_DIO];
        last_q <= reg_wdata_i[`SCD_STX_LAST];
      end
    end
  end
  wire deb_en = crd_q[`SCD_CRD_DEB];
  wire det_en = crd_q[`SCD_CRD_EN];
  wire det_pol = crd_q[`SCD_CRD_POL];
  // Pull controls straight from the control bits.
  assign pullup_enable_n_o = crd_q[`SCD_CRD_PU];
  assign pulldown_enable_o = crd_q[`SCD_CRD_PD];

  // ==========================================================
  // Synchronisers for pins from outside the clock domain
  logic [1:0] det_s;
  logic [1:0] pwr_s;
  logic [2:0] ss_s;
  logic [2:0] ck_s;
  logic [1:0] io_s;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      det_s <= 2'h0;
      pwr_s <= 2'h0;
      ss_s <= 3'h0;
      ck_s <= 3'h0;
      io_s <= 2'h3;
    end else begin
      det_s <= {det_s[0], card_detect_pin_i};
      pwr_s <= {pwr_s[0], power_down_bit_i};
      ss_s <= {ss_s[1:0], supply_stable_i};
      ck_s <= {ck_s[1:0], card_clk_i};
      io_s <= {io_s[0], io_line_i};
    end
  end

  // ==========================================================
  // Card detect
  // The detect path runs on the free system clock, never on the card
  // clock, so stopping the card clock does not blind it.
  // Free-running detect.
  wire det_w = det_en & (det_pol ? det_s[1] : ~det_s[1]);
  logic [14:0] tick_cnt_q;
  wire tick = tick_cnt_q == 15'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= 15'h0;
    end else begin
      tick_cnt_q <= tick ? 15'h0 : tick_cnt_q + 15'h1;
    end
  end
  logic [6:0] deb_cnt_q;
  wire deb_done = deb_cnt_q == `SCD_DEBOUNCE_MS;
  // Count ticks up to the stable interval.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      deb_cnt_q <= 7'h0;
    end else if (!det_w) begin
      deb_cnt_q <= 7'h0;
    end else if (tick && !deb_done) begin
      deb_cnt_q <= deb_cnt_q + 7'h1;
    end
  end
  logic present_q;
  logic card_event_q;
  logic deact_q;
  wire present_d = det_w & (pwr_s[1] | ~deb_en | deb_done);
  wire ss_fall = ss_s[2] & ~ss_s[1];
  // Every change is a card event.
  // Card event or supply loss deactivates.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      present_q <= 1'b0;
      card_event_q <= 1'b0;
      deact_q <= 1'b0;
    end else begin
      present_q <= present_d;
      card_event_q <= present_d ^ present_q;
      deact_q <= (present_d ^ present_q) | ss_fall;
    end
  end
  assign card_present_o = present_q;
  assign card_event_o = card_event_q;
  assign deactivate_o = deact_q;

  // ==========================================================
  // Transmit status flags
  logic done_q;
  logic empty_q;
  logic full_q;
  logic undr_q;
  logic brk_q;
  logic tx_evt_q;
  logic tx_err_q;
  scd_dir_type dir_q;
  wire tx_active = dir_q != DIR_RX;
  wire chk_mode = mode_i.t1_mode & mode_i.check_code_en;
  // T=0 finishes on the final word.
  // T=1 with check code finishes on the check code.
  wire done_ev = chk_mode ? tx_stat_i.crc_sent
               : tx_stat_i.word_sent & tx_stat_i.fifo_empty;
  // Empty follows the FIFO unless a message tail is pending.
  wire empty_d = tx_stat_i.fifo_empty & (~last_q | done_q | done_ev);
  // Underrun on empty after a word without last.
  wire undr_ev = tx_stat_i.word_sent & tx_stat_i.fifo_empty & ~last_q;
  wire ck_rise = ck_s[1] & ~ck_s[2];
  // Card pulls IO low at the guard time.
  wire brk_ev = tx_active & tx_stat_i.break_window & ck_rise & ~io_s[1];
  // Set wins over the clear on read.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      empty_q <= 1'b1;
      full_q <= 1'b0;
      undr_q <= 1'b0;
      brk_q <= 1'b0;
      tx_evt_q <= 1'b0;
      tx_err_q <= 1'b0;
    end else begin
      done_q <= last_q & (done_q | done_ev);
      empty_q <= empty_d;
      full_q <= tx_stat_i.fifo_full;
      undr_q <= undr_ev | (undr_q & ~rd_stx);
      brk_q <= brk_ev | (brk_q & ~rd_stx);
      tx_evt_q <= (tx_stat_i.fifo_full & ~full_q) | (empty_d & ~empty_q);
      tx_err_q <= undr_ev | brk_ev;
    end
  end
  assign tx_event_irq_o = tx_evt_q;
  assign tx_error_irq_o = tx_err_q;

  // ==========================================================
  // Direction control
  // A receive request made while a flagged message is still draining is
  // held in DIR_DRAIN so the tail and its check code still go out.
  scd_dir_type dir_d;
  wire wr_dir = reg_wdata_i[`SCD_STX_DIR];
  always_comb begin
    dir_d = dir_q;
    case (dir_q)
      DIR_RX: begin
        if (wr_stx && wr_dir) begin
          dir_d = DIR_TX;
        end
      end
      DIR_TX: begin
        if (wr_stx && !wr_dir) begin
          dir_d = (last_q && !empty_q) ? DIR_DRAIN : DIR_RX;
        end
      end
      DIR_DRAIN: begin
        if (wr_stx && wr_dir) begin
          dir_d = DIR_TX;
        end else if (empty_q) begin
          dir_d = DIR_RX;
        end
      end
      default: begin
        dir_d = DIR_RX;
      end
    endcase
  end
  logic crc_init_q;
  wire leave_tx = tx_active & (dir_d == DIR_RX);
  // Reinitialise check code on leaving transmit.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_q <= DIR_RX;
      crc_init_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
      crc_init_q <= leave_tx;
    end
  end
  assign tx_mode_o = tx_active;
  assign rx_mode_o = ~tx_active;
  assign crc_init_o = crc_init_q;
  // Queued bytes go out only in transmit mode.
  assign send_enable_o = tx_active & ~tx_stat_i.fifo_empty;
  // Ask for the check code once the flagged message drained.
  assign append_check_o = tx_active & chk_mode & last_q
                        & tx_stat_i.fifo_empty & ~done_q;

  // ==========================================================
  // IO source
  wire len_edge = (length_count_i == `SCD_LEN_MAX)
                | (length_count_i == `SCD_LEN_ZERO);
  // Direct IO from the control bit.
  wire io_direct = mode_i.sync_mode & direct_io_q & len_edge;
  logic io_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      io_q <= 1'b1;
    end else begin
      io_q <= io_direct ? card_io_bit_i : fifo_bit_i;
    end
  end
  assign io_out_o = io_q;

  // ==========================================================
  // Read path
  logic [7:0] crd_rd;
  logic [7:0] stx_rd;
  logic [7:0] rdata_q;
  always_comb begin
    crd_rd = {deb_en, det_en, 2'h0, det_pol, pullup_enable_n_o,
              pulldown_enable_o, present_q};
    stx_rd = {direct_io_q, 1'b0, full_q, empty_q, undr_q, last_q,
              tx_active, brk_q};
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= `SCD_RD_NONE;
    end else if (reg_rd_i && sel_crd) begin
      rdata_q <= crd_rd;
    end else if (rd_stx) begin
      rdata_q <= stx_rd;
    end else begin
      rdata_q <= `SCD_RD_NONE;
    end
  end
  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // Assertions
  property p_present_clear;
    !det_w |=> !present_q;
  endproperty
  a_present_clear: assert property (p_present_clear)
    else $error("presence not cleared on deassertion");
  property p_debounce_wait;
    present_q && !$past(present_q) && $past(deb_en && !pwr_s[1])
      |-> $past(deb_done);
  endproperty
  a_debounce_wait: assert property (p_debounce_wait)
    else $error("presence set before debounce interval");
  property p_power_down_bit_direct;
    det_w && pwr_s[1] |=> present_q;
  endproperty
  a_power_down_bit_direct: assert property (p_power_down_bit_direct)
    else $error("power-down presence was debounced");
  property p_card_event;
    $changed(present_q) |-> card_event_o && deactivate_o;
  endproperty
  a_card_event: assert property (p_card_event)
    else $error("presence change without card event");
  property p_deact;
    card_event_o |-> deactivate_o;
  endproperty
  a_deact: assert property (p_deact)
    else $error("card event without deactivation");
  property p_underrun;
    undr_ev |=> undr_q ##1 (undr_q || $past(rd_stx));
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun flag not held");
  property p_read_clear;
    rd_stx && !undr_ev |=> !undr_q;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("underrun flag survived a read");
  property p_io_direct;
    io_direct |=> io_out_o == $past(card_io_bit_i);
  endproperty
  a_io_direct: assert property (p_io_direct)
    else $error("IO not taken from control bit");
  property p_empty_hold;
    last_q && !done_q && $past(last_q && !done_q) |-> !empty_q;
  endproperty
  a_empty_hold: assert property (p_empty_hold)
    else $error("empty set before message tail sent");
  property p_full_event;
    $rose(full_q) |-> tx_event_irq_o;
  endproperty
  a_full_event: assert property (p_full_event)
    else $error("no transmit event on full");
  property p_drain;
    dir_q == DIR_DRAIN && empty_q && !wr_stx |=> dir_q == DIR_RX;
  endproperty
  a_drain: assert property (p_drain)
    else $error("drain did not return to receive");
  property p_crc_init;
    $fell(tx_mode_o) |-> crc_init_o;
  endproperty
  a_crc_init: assert property (p_crc_init)
    else $error("check code logic not reinitialised");
  c_debounced: cover property (deb_en && $rose(present_q));
  c_drain: cover property (dir_q == DIR_DRAIN ##[1:300] dir_q == DIR_RX);
  c_break: cover property (brk_ev);
  c_direct: cover property (io_direct);

endmodule

// File: scd_card_model.sv
// Behavioural smart card standing on the IO line of the block.
`timescale 1ns/1ps

// ==========================================================
// Card model
module scd_card_model (
  input wire logic frame_i,
  input wire logic break_i,
  output logic card_clk_o,
  output logic io_line_o
);
  // The card clock stands still between frames; it runs at 320 ns.
  initial begin
    card_clk_o = 1'h0;
    forever begin
      #160;
      card_clk_o = frame_i ? ~card_clk_o : 1'h0;
    end
  end

  // parity error break
  // The line has a pull-up, so a released line reads high.
  assign io_line_o = ~(frame_i & break_i);
endmodule

// File: smart_card_detect_and_tx_control_tb_top.sv
// Self-checking bench for the card detect and transmit control block.
`timescale 1ns/1ps
`include "scd_regs.svh"

// ==========================================================
// Bench top
module smart_card_detect_and_tx_control_tb_top
  import scd_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rdata;
  logic [7:0] len = '0;
  logic wr = 1'h0, rd = 1'h0, rd_d = 1'h0, pin = 1'h0, pwd = 1'h0;
  logic vok = 1'h1, cio = 1'h0, fbit = 1'h0, frame = 1'h0, brk = 1'h0;
  logic cclk, ioln, pu_n, pd, pres, cev, dea, io_o, txm, rxm, send, app;
  logic crci, tev, terr;
  scd_mode_type mode = '0;
  scd_tx_stat_type st = 5'h08;
  int bad_count = 0, tests_run = 0;
  int n_cev = 0, n_dea = 0, n_tev = 0, n_ter = 0, n_crc = 0;
  logic [7:0] expq[$];

  scd_ctrl #(.TICK_CYCLES(4)) i_scd_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .card_detect_pin_i(pin), .power_down_bit_i(pwd), .supply_stable_i(vok),
    .pullup_enable_n_o(pu_n), .pulldown_enable_o(pd), .card_present_o(pres),
    .card_event_o(cev), .deactivate_o(dea), .mode_i(mode),
    .length_count_i(len), .card_io_bit_i(cio), .fifo_bit_i(fbit),
    .tx_stat_i(st), .io_line_i(ioln), .card_clk_i(cclk), .io_out_o(io_o),
    .tx_mode_o(txm), .rx_mode_o(rxm), .send_enable_o(send),
    .append_check_o(app), .crc_init_o(crci), .tx_event_irq_o(tev),
    .tx_error_irq_o(terr));

  scd_card_model i_scd_card_model (
    .frame_i(frame), .break_i(brk), .card_clk_o(cclk), .io_line_o(ioln));

  initial forever #20 clk_i = ~clk_i;

  // ==========================================================
  // Compare tasks
  task automatic chk_bit(string nm, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(string nm, int e, int g);
    tests_run++;
    if (g != e) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Drivers
  task automatic wt(int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
  endtask

  // The expected byte is queued as the strobe goes out.
  task automatic rd_exp(logic [15:0] a, logic [7:0] e);
    @(posedge clk_i);
    expq.push_back(e);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
  endtask

  task automatic strobe(int b);
    @(posedge clk_i);
    st[b] <= 1'h1;
    @(posedge clk_i);
    st[b] <= 1'h0;
  endtask

  // ==========================================================
  // Monitor
  always @(posedge clk_i) begin
    if (rd_d && expq.size() > 0) begin
      chk_byte("read data", expq.pop_front(), rdata);
    end
    rd_d <= rd;
    if (rst_n_i) begin
      n_cev <= n_cev + int'(cev);
      n_dea <= n_dea + int'(dea);
      n_tev <= n_tev + int'(tev);
      n_ter <= n_ter + int'(terr);
      n_crc <= n_crc + int'(crci);
    end
  end

  // A hang is cut short well past the expected run of some 650 cycles.
  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(76853));
    wt(4);
    rst_n_i <= 1'h1;
    rd_exp(`SCD_ADDR_CRD, `SCD_CRD_RESET);
    rd_exp(`SCD_ADDR_STX, 8'h10);
    rd_exp(16'hfe07, `SCD_RD_NONE);
    wr_reg(`SCD_ADDR_CRD, 8'hff);
    rd_exp(`SCD_ADDR_CRD, 8'hce);
    chk_bit("pullup_n", 1'h1, pu_n);
    chk_bit("pulldown", 1'h1, pd);
    wr_reg(`SCD_ADDR_CRD, 8'h08);
    pin <= 1'h1;
    wt(6);
    chk_bit("present", 1'h0, pres);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      wr_reg(`SCD_ADDR_CRD, {4'h0, p[0], 3'h0});
      pin <= ~p[0];
      wr_reg(`SCD_ADDR_CRD, {4'h4, p[0], 3'h0});
      wt(6);
      chk_bit("present", 1'h0, pres);
      pin <= p[0];
      wt(6);
      chk_bit("present", 1'h1, pres);
      pin <= ~p[0];
      wt(4);
      chk_bit("present", 1'h0, pres);
    end
    chk_bit("pullup_n", 1'h0, pu_n);
    chk_bit("pulldown", 1'h0, pd);
    wt(2);
    chk_cnt("card events", 4, n_cev);
    chk_cnt("deactivations", 4, n_dea);
    $display("test polarity done");
    wr_reg(`SCD_ADDR_CRD, 8'h88);
    wr_reg(`SCD_ADDR_CRD, 8'hc8);
    pin <= 1'h1;
    wt(100);
    pin <= 1'h0;
    wt(10);
    pin <= 1'h1;
    wt(245);
    chk_bit("present", 1'h0, pres);
    wt(30);
    chk_bit("present", 1'h1, pres);
    rd_exp(`SCD_ADDR_CRD, 8'hc9);
    pin <= 1'h0;
    wt(4);
    chk_bit("present", 1'h0, pres);
    pwd <= 1'h1;
    wt(4);
    pin <= 1'h1;
    wt(6);
    chk_bit("present", 1'h1, pres);
    pin <= 1'h0;
    pwd <= 1'h0;
    wt(6);
    vok <= 1'h0;
    wt(6);
    chk_cnt("deactivations", 9, n_dea);
    vok <= 1'h1;
    $display("test debounce done");
    wr_reg(`SCD_ADDR_STX, 8'h02);
    wt(2);
    chk_bit("tx mode", 1'h1, txm);
    chk_bit("rx mode", 1'h0, rxm);
    chk_bit("send", 1'h0, send);
    st[3] <= 1'h0;
    wt(3);
    chk_bit("send", 1'h1, send);
    st[4] <= 1'h1;
    wt(3);
    rd_exp(`SCD_ADDR_STX, 8'h22);
    chk_cnt("tx events", 1, n_tev);
    st[4] <= 1'h0;
    st[3] <= 1'h1;
    wt(3);
    chk_cnt("tx events", 2, n_tev);
    strobe(2);
    wt(3);
    chk_cnt("tx errors", 1, n_ter);
    rd_exp(`SCD_ADDR_STX, 8'h1a);
    rd_exp(`SCD_ADDR_STX, 8'h12);
    st[3] <= 1'h0;
    wr_reg(`SCD_ADDR_STX, 8'h06);
    st[3] <= 1'h1;
    wt(3);
    rd_exp(`SCD_ADDR_STX, 8'h06);
    wr_reg(`SCD_ADDR_STX, 8'h04);
    wt(2);
    chk_bit("tx mode", 1'h1, txm);
    strobe(2);
    wt(4);
    chk_bit("tx mode", 1'h0, txm);
    chk_cnt("tx events", 3, n_tev);
    chk_cnt("check inits", 1, n_crc);
    rd_exp(`SCD_ADDR_STX, 8'h14);
    wr_reg(`SCD_ADDR_STX, 8'h00);
    $display("test transmit done");
    mode <= 3'h3;
    st[3] <= 1'h0;
    wr_reg(`SCD_ADDR_STX, 8'h06);
    st[3] <= 1'h1;
    strobe(2);
    wt(2);
    chk_bit("append", 1'h1, app);
    rd_exp(`SCD_ADDR_STX, 8'h06);
    strobe(1);
    wt(3);
    rd_exp(`SCD_ADDR_STX, 8'h16);
    wr_reg(`SCD_ADDR_STX, 8'h00);
    wt(3);
    chk_cnt("check inits", 2, n_crc);
    $display("test check code done");
    mode <= 3'h0;
    wr_reg(`SCD_ADDR_STX, 8'h02);
    frame <= 1'h1;
    brk <= 1'h1;
    st[0] <= 1'h1;
    wt(40);
    brk <= 1'h0;
    st[0] <= 1'h0;
    wt(20);
    frame <= 1'h0;
    chk_bit("break error", 1'h1, n_ter > 1);
    rd_exp(`SCD_ADDR_STX, 8'h13);
    rd_exp(`SCD_ADDR_STX, 8'h12);
    $display("test break done");
    mode <= 3'h4;
    wr_reg(`SCD_ADDR_STX, 8'h80);
    for (int i = 0; i < 9; i++) begin
      len <= (i % 3 == 0) ? 8'hff : (i % 3 == 1) ? 8'h00 : 8'h05;
      cio <= 1'($urandom);
      fbit <= 1'($urandom);
      wt(3);
      chk_bit("io out", (i % 3 == 2) ? fbit : cio, io_o);
    end
    rd_exp(`SCD_ADDR_STX, 8'h90);
    wt(3);
    $display("test direct io done");
    summarize();
  end
endmodule
